// File: mdv_pkg.sv
// shared constants and types for the 16x16 multiplier/divider
package mdv_pkg;
  localparam int DW = 16;
  // instruction codes
  localparam logic [2:0] CODE_DIV = 3'h4;
  localparam logic [2:0] CODE_FRAC = 3'h5;
  localparam logic [2:0] CODE_INT = 3'h6;
  localparam logic [2:0] CODE_READ = 3'h7;
  localparam logic [2:0] CODE_ROUND = 3'h5;
  // cycle counts, including the operand load cycle
  localparam int MUL_CYCLES = 9;
  localparam int DIV_INT_CYCLES = 21;
  localparam int DIV_FRAC_CYCLES = DIV_INT_CYCLES - 1;
  localparam int INIT_MAX_CYCLES = 21;
  localparam int CNT_W = 5;
  // reset values
  localparam logic [DW-1:0] REG_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_OPND,
    ST_OPZ,
    ST_OPW,
    ST_MUL,
    ST_MEND,
    ST_DIV,
    ST_DEND
  } mdv_state_t;
  // shared bus drive side
  typedef struct packed {
    logic oe_n;
    logic [DW-1:0] data;
  } mdv_bus_drv_t;
endpackage

// File: mdv_core.sv
// sequencer-controlled 16x16 multiplier and 32/16 divider
`timescale 1ns/1ps
`default_nettype none

module mdv_core #(
  parameter int MUL_CYC = mdv_pkg::MUL_CYCLES,
  parameter int DIV_CYC = mdv_pkg::DIV_INT_CYCLES
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // host control
  input wire logic go_n,
  input wire logic [2:0] instr_code,
  // shared bus
  input wire logic [mdv_pkg::DW-1:0] bidir_bus,
  output var mdv_pkg::mdv_bus_drv_t bus_drv,
  // status
  output logic arith_overflow_flag
);
  import mdv_pkg::*;

  if (MUL_CYC < 3 || DIV_CYC < 4 || DIV_CYC > 31 || MUL_CYC > 31) begin : g_chk
    $error("mdv_core: cycle counts out of range");
  end

  mdv_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [DW-1:0] z, next_z, w, next_w;
  logic [DW-1:0] prior_operand_rank, next_prior;
  logic [DW-1:0] xw, next_xw, y, next_y;
  logic frac, next_frac, neg, next_neg, acc, next_acc;
  logic next_ovf;

  // arithmetic results, used at the last compute cycle
  logic signed [33:0] prod34, addend34, sum34;
  logic signed [33:0] dvd34, dvs34, quo34, rem34;
  logic mul_ovf, div_ovf;

  logic act, is_read, wait_st, load_st;
  assign act = clk_en & ~go_n;
  assign is_read = act & (instr_code == CODE_READ);
  assign wait_st = (state != ST_MUL) && (state != ST_DIV);
  assign load_st = (state == ST_OPND) || (state == ST_OPZ) ||
                   (state == ST_OPW);

  // bus is driven from the high half register during read cycles in the idle and end states
  always_comb begin
    bus_drv.data = z;
    bus_drv.oe_n = ~(is_read && wait_st && !load_st);
  end

  always_comb begin
    // product in 2^-31 (fractional) or 2^0 (integer) weight
    prod34 = 34'(signed'(xw) * signed'(y));
    if (frac) begin
      prod34 = 34'(prod34 <<< 1);
    end
    if (neg) begin
      prod34 = -prod34;
    end
    addend34 = acc ? 34'(signed'({z, w})) : 34'sh0;
    sum34 = prod34 + addend34;
    mul_ovf = (sum34[33:31] != 3'h0) && (sum34[33:31] != 3'h7);
    // divisor doubled in fractional mode so the quotient stays Q15
    dvd34 = 34'(signed'({z, w}));
    dvs34 = frac ? 34'(signed'({xw, 1'b0})) : 34'(signed'(xw));
    if (xw == REG_RST) begin
      quo34 = 34'sh0;
      rem34 = dvd34;
    end else begin
      quo34 = dvd34 / dvs34;
      rem34 = 34'(dvd34 - quo34 * dvs34);
    end
    div_ovf = (xw == REG_RST) ||
              (quo34 > 34'sh7FFF) || (quo34 < -34'sh8000);
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_z = z;
    next_w = w;
    next_prior = prior_operand_rank;
    next_xw = xw;
    next_y = y;
    next_frac = frac;
    next_neg = neg;
    next_acc = acc;
    next_ovf = arith_overflow_flag;
    if (clk_en) begin
      unique case (state)
        ST_MUL, ST_DIV: begin
          // loading while processing into the first operand rank
          if (act && instr_code == CODE_INT) begin
            next_prior = bidir_bus;
          end
          if (cnt != CNT_RST) begin
            next_cnt = cnt - 5'h01;
          end else if (state == ST_MUL) begin
            next_state = ST_MEND;
            next_z = sum34[31:16];
            next_w = sum34[15:0];
            next_ovf = mul_ovf;
          end else begin
            next_state = ST_DEND;
            next_z = quo34[15:0];
            next_w = rem34[15:0];
            next_ovf = div_ovf;
          end
        end
        default: begin
          if (act) begin
            if (instr_code == CODE_READ) begin
              next_state = ST_IDLE;
              if (!load_st) begin
                next_z = w;
                next_w = z;
              end
              next_ovf = 1'b0;
            end else if (instr_code[2] == 1'b0) begin
              // start a multiply, Y from the bus
              next_y = bidir_bus;
              next_xw = prior_operand_rank;
              next_neg = instr_code[0];
              next_acc = instr_code[1] || state == ST_OPZ ||
                         state == ST_OPW || state == ST_MEND ||
                         state == ST_DEND;
              if (state == ST_IDLE || state == ST_OPND) begin
                next_acc = instr_code[1];
              end
              if (state == ST_OPZ && instr_code[1]) begin
                next_w = z;
                next_z = {DW{z[DW-1]}};
              end
              if (state == ST_OPW && instr_code[1]) begin
                next_z = {DW{w[DW-1]}};
              end
              if ((state == ST_MEND || state == ST_DEND) &&
                  !instr_code[1]) begin
                next_acc = 1'b0;
              end
              next_state = ST_MUL;
              next_cnt = CNT_W'(MUL_CYC - 3);
              next_ovf = 1'b0;
            end else if ((state == ST_MEND || state == ST_DEND) &&
                         instr_code == CODE_ROUND) begin
              if (state == ST_MEND) begin
                next_z = z + {15'h0000, w[DW-1]};
              end else begin
                next_z = {z[DW-1:1], z[0] | (w != REG_RST)};
              end
              next_w = REG_RST;
              next_state = ST_IDLE;
            end else if (instr_code == CODE_INT &&
                         (state == ST_OPZ || state == ST_OPW)) begin
              next_w = bidir_bus;
              next_state = ST_OPW;
            end else if (instr_code == CODE_INT && state == ST_OPND) begin
              next_z = bidir_bus;
              next_w = REG_RST;
              next_state = ST_OPZ;
            end else if (instr_code != CODE_DIV &&
                         (state == ST_IDLE || state == ST_MEND ||
                          state == ST_DEND)) begin
              next_prior = bidir_bus;
              if (state == ST_IDLE) begin
                next_frac = (instr_code == CODE_FRAC);
              end
              next_state = ST_OPND;
            end else begin
              // divide start: code 4 anywhere, code 5 after operand
              next_xw = prior_operand_rank;
              if (state == ST_OPND && instr_code == CODE_DIV) begin
                next_z = {DW{w[DW-1]}};
              end else if (state == ST_OPND) begin
                next_w = REG_RST;
              end else if (state == ST_OPZ && instr_code == CODE_DIV) begin
                next_w = bidir_bus;
              end
              // a high half filled with the sign of w makes this a single-length divide
              next_state = ST_DIV;
              next_cnt = frac ? CNT_W'(DIV_CYC - 4) :
                                CNT_W'(DIV_CYC - 3);
              if (state == ST_IDLE && instr_code == CODE_DIV) begin
                next_cnt = frac ? CNT_W'(DIV_CYC - 4) :
                                  CNT_W'(DIV_CYC - 3);
              end
              next_ovf = 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cnt <= CNT_RST;
      z <= REG_RST;
      w <= REG_RST;
      prior_operand_rank <= REG_RST;
      xw <= REG_RST;
      y <= REG_RST;
      frac <= 1'b0;
      neg <= 1'b0;
      acc <= 1'b0;
      arith_overflow_flag <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      z <= next_z;
      w <= next_w;
      prior_operand_rank <= next_prior;
      xw <= next_xw;
      y <= next_y;
      frac <= next_frac;
      neg <= next_neg;
      acc <= next_acc;
      arith_overflow_flag <= next_ovf;
    end
  end

  // helper: consecutive enabled cycles with read code held
  logic [CNT_W-1:0] hold7;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hold7 <= CNT_RST;
    end else if (clk_en) begin
      if (!is_read) begin
        hold7 <= CNT_RST;
      end else if (hold7 != 5'h1F) begin
        hold7 <= hold7 + 5'h01;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  chk_bus_read_only: assert property (
    !bus_drv.oe_n |-> (!go_n && clk_en && instr_code == CODE_READ &&
      (state == ST_IDLE || state == ST_MEND || state == ST_DEND)))
    else $error("bus driven outside a read cycle");
  chk_wait_hold_state: assert property (
    (clk_en && go_n && wait_st) |=> (state == $past(state) && z == $past(z)))
    else $error("state moved while activation high");
  chk_read_swap_halves: assert property (
    (is_read && state == ST_IDLE) |=> (z == $past(w) && w == $past(z)))
    else $error("idle read did not swap halves");
  chk_abort_loading: assert property (
    (is_read && load_st) |=> state == ST_IDLE)
    else $error("read did not abort loading");
  chk_init_bound: assert property (
    hold7 >= 5'(INIT_MAX_CYCLES) |-> state == ST_IDLE)
    else $error("held read code did not reach idle");
  chk_div_length: assert property (
    (clk_en && state != ST_DIV && next_state == ST_DIV) |=>
      cnt == (frac ? 5'(DIV_CYC - 4) : 5'(DIV_CYC - 3)))
    else $error("divide length wrong for mode");
  chk_round_mul: assert property (
    (act && state == ST_MEND && instr_code == CODE_ROUND) |=>
      (state == ST_IDLE && w == 16'h0000 &&
       z == 16'($past(z) + {15'h0000, $past(w[15])})))
    else $error("multiply rounding wrong");
  chk_round_div: assert property (
    (act && state == ST_DEND && instr_code == CODE_ROUND) |=>
      (w == 16'h0000 && z[0] == ($past(z[0]) || $past(w) != 16'h0000)))
    else $error("divide rounding wrong");
  chk_ovf_clear_read: assert property (
    (is_read && (state == ST_MEND || state == ST_DEND)) |=>
      !arith_overflow_flag ##1 (state == ST_IDLE || !is_read))
    else $error("overflow not cleared on read");
  chk_ovf_stable_run: assert property (
    (clk_en && state == ST_MUL && cnt != 5'h00) |=>
      $stable(arith_overflow_flag) && !arith_overflow_flag)
    else $error("overflow moved during multiply");

endmodule // mdv_core

`default_nettype wire

// File: mdv_host_model.sv
// host-side model: drives the controls and shares the data bus
`timescale 1ns/1ps
`default_nettype none
module mdv_host_model (
  // clock
  input wire logic mclk,
  // device side
  input wire mdv_pkg::mdv_bus_drv_t bus_drv,
  // host control and bus
  output logic go_n,
  output logic [2:0] instr_code,
  output wire logic [mdv_pkg::DW-1:0] bidir_bus
);
  import mdv_pkg::*;
  logic [DW-1:0] hval = 16'h0000;
  logic [DW-1:0] last = 16'h0000;
  logic hdrv = 1'b0;
  initial begin
    go_n = 1'b1;
    instr_code = 3'h7;
  end
  // a released bus shows the inverse of its last level, never a held value
  assign bidir_bus = (bus_drv.oe_n === 1'b0) ? bus_drv.data :
                     hdrv ? hval : ~last;
  always @(posedge mclk) last <= bidir_bus;
  // controls move just after the rising edge, while the clock is high
  task automatic step(input logic g, input logic [2:0] c,
                      input logic [DW-1:0] d);
    @(posedge mclk);
    #2;
    go_n = g;
    instr_code = c;
    hdrv = (c != CODE_READ) && !g;
    hval = d;
  endtask
endmodule // mdv_host_model
`default_nettype wire

// File: multiplier_divider_16x16_tb_top.sv
// self-checking bench for the multiplier/divider core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module multiplier_divider_16x16_tb_top;
  import mdv_pkg::*;
  localparam int MC = 4;
  localparam int DC = 6;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic go_n;
  logic [2:0] instr_code;
  wire logic [DW-1:0] bidir_bus;
  mdv_bus_drv_t bus_drv;
  logic arith_overflow_flag;
  int errors = 0;
  int checked = 0;
  logic [DW-1:0] rz;
  logic [DW-1:0] rw;
  logic rov;
  int n0;
  int n1;
  always #12.5 mclk = ~mclk;
  mdv_core #(.MUL_CYC(MC), .DIV_CYC(DC)) mdv_core_inst (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .go_n(go_n),
    .instr_code(instr_code), .bidir_bus(bidir_bus), .bus_drv(bus_drv),
    .arith_overflow_flag(arith_overflow_flag));
  mdv_host_model mdv_host_model_inst (
    .mclk(mclk), .bus_drv(bus_drv), .go_n(go_n),
    .instr_code(instr_code), .bidir_bus(bidir_bus));
  task automatic results();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic hs(input logic g, input logic [2:0] c,
                    input logic [DW-1:0] d);
    mdv_host_model_inst.step(g, c, d);
  endtask
  // code 7 is ignored while computing, so the wait also counts cycles
  task automatic rd(output int n);
    n = 0;
    do begin
      hs(1'b0, CODE_READ, 16'h0000);
      #1;
      n++;
    end while (bus_drv.oe_n !== 1'b0 && n < 60);
    `CHK(bus_drv.oe_n, 1'b0)
    rz = bus_drv.data;
    rov = arith_overflow_flag;
    hs(1'b0, CODE_READ, 16'h0000);
    #1;
    rw = bus_drv.data;
    `CHK(arith_overflow_flag, 1'b0)
  endtask
  task automatic mul(input logic [2:0] m, c, input logic [DW-1:0] x, y,
                     output int n);
    hs(1'b0, m, x);
    hs(1'b0, c, y);
    rd(n);
  endtask
  task automatic div(input logic [2:0] m, input logic [DW-1:0] x, z, w,
                     output int n);
    hs(1'b0, m, x);
    hs(1'b0, CODE_INT, z);
    hs(1'b0, CODE_DIV, w);
    rd(n);
  endtask
  task automatic t_reset();
    hs(1'b1, CODE_READ, 16'h0000);
    #1;
    `CHK(bus_drv.oe_n, 1'b1)
    hs(1'b0, CODE_READ, 16'h0000);
    #1;
    `CHK(bus_drv.data, 16'h0000)
  endtask
  task automatic t_imul();
    mul(CODE_INT, 3'h0, 16'h7FFF, 16'h7FFF, n0);
    `CHK({rz, rw}, 32'h3FFF0001)
    mul(CODE_INT, 3'h0, 16'h8000, 16'h8000, n0);
    `CHK({rz, rw, rov}, {32'h40000000, 1'b0})
  endtask
  task automatic t_fmul();
    mul(CODE_FRAC, 3'h0, 16'h4000, 16'h4000, n0);
    `CHK({rz, rw}, 32'h20000000)
    mul(CODE_FRAC, 3'h1, 16'h4000, 16'h4000, n1);
    `CHK({rz, rw}, 32'hE0000000)
    `CHK(n0, n1)
    mul(CODE_FRAC, 3'h0, 16'h8000, 16'h8000, n0);
    `CHK(rov, 1'b1)
  endtask
  // chain without reading keeps fractional mode; accumulation costs no cycles
  task automatic t_chain();
    hs(1'b0, CODE_FRAC, 16'h4000);
    hs(1'b0, 3'h0, 16'h4000);
    repeat (MC + 2) hs(1'b1, CODE_READ, 16'h0000);
    hs(1'b0, CODE_INT, 16'h2000);
    hs(1'b0, 3'h2, 16'h4000);
    rd(n0);
    `CHK({rz, rw}, 32'h30000000)
    hs(1'b0, 3'h3, 16'h4000);
    rd(n1);
    `CHK({rz, rw}, 32'h20000000)
    `CHK(n0, n1)
  endtask
  // end-state wait with go_n high, then round instead of read
  task automatic t_round();
    hs(1'b0, CODE_FRAC, 16'h0001);
    hs(1'b0, 3'h0, 16'h4000);
    repeat (MC + 4) begin
      hs(1'b1, CODE_READ, 16'h0000);
      #1;
      `CHK(bus_drv.oe_n, 1'b1)
    end
    hs(1'b0, CODE_ROUND, 16'h0000);
    rd(n0);
    `CHK({rz, rw}, 32'h00010000)
  endtask
  task automatic t_div();
    div(CODE_INT, 16'h0007, 16'hFFFF, 16'hFF9C, n0);
    `CHK({rz, rw}, 32'hFFF2FFFE)
    div(CODE_FRAC, 16'h4000, 16'h2000, 16'h0000, n1);
    `CHK({rz, rw}, 32'h40000000)
    `CHK(n0 - n1, 1)
    div(CODE_INT, 16'h0001, 16'h0001, 16'h0000, n0);
    `CHK(rov, 1'b1)
    hs(1'b0, CODE_INT, 16'h0007);
    hs(1'b0, CODE_INT, 16'h0000);
    hs(1'b0, CODE_DIV, 16'h0064);
    repeat (DC + 4) hs(1'b1, CODE_READ, 16'h0000);
    hs(1'b0, CODE_ROUND, 16'h0000);
    rd(n0);
    `CHK({rz, rw}, 32'h000F0000)
  endtask
  // a read in mid-load aborts without driving; idle reads then swap
  task automatic t_abort();
    hs(1'b0, CODE_INT, 16'h1234);
    hs(1'b0, CODE_READ, 16'h0000);
    #1;
    `CHK(bus_drv.oe_n, 1'b1)
    hs(1'b0, CODE_READ, 16'h0000);
    #1;
    `CHK(bus_drv.data, rz)
    hs(1'b0, CODE_READ, 16'h0000);
    #1;
    `CHK(bus_drv.data, rw)
    hs(1'b0, CODE_READ, 16'h0000);
    #1;
    `CHK(bus_drv.data, rz)
  endtask
  // clock enable low freezes everything, so the held read swaps nothing
  task automatic t_freeze();
    @(posedge mclk);
    #2;
    clk_en = 1'b0;
    repeat (3) begin
      @(posedge mclk);
      #2;
      `CHK(bus_drv.oe_n, 1'b1)
    end
    clk_en = 1'b1;
    #1;
    `CHK(bus_drv.data, rw)
  endtask
  // a held read code brings the sequencer home from mid-divide
  task automatic t_init();
    hs(1'b0, CODE_INT, 16'h0007);
    hs(1'b0, CODE_INT, 16'h0000);
    hs(1'b0, CODE_DIV, 16'h0064);
    repeat (INIT_MAX_CYCLES + 2) hs(1'b0, CODE_READ, 16'h0000);
    #1;
    `CHK(bus_drv.oe_n, 1'b0)
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    #2;
    reset_n = 1'b1;
    t_reset();
    t_imul();
    t_fmul();
    t_chain();
    t_round();
    t_div();
    t_abort();
    t_freeze();
    t_init();
    results();
  end
  // whole run needs about 150 cycles; this limit is far above it
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    results();
  end
endmodule // multiplier_divider_16x16_tb_top
`default_nettype wire
